// file: bsr_ahb_mst.sv
// Purpose: behavioural ahb-lite masters, one per port of the sram front end
// Assumes: single beats, one outstanding transfer per port, hready fed back
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module bsr_ahb_mst import bsr_pkg::*; #(
    parameter int NM = NUM_MASTERS,
    parameter int WAIT_MAX = 64
) (
    // clock
    input wire logic ref_clk,
    // request lines
    output logic [NM-1:0] hsel,
    output logic [NM-1:0][ADDR_W-1:0] haddr,
    output logic [NM-1:0][1:0] htrans,
    output logic [NM-1:0] hwrite,
    output logic [NM-1:0][2:0] hsize,
    output logic [NM-1:0][DATA_W-1:0] hwdata,
    // answer lines
    input wire logic [NM-1:0][DATA_W-1:0] hrdata,
    input wire logic [NM-1:0] hreadyout,
    input wire logic [NM-1:0] hresp
);
    // ==========================================================
    // idle lines at time zero
    initial begin
        hsel = '0;
        haddr = '0;
        htrans = '0;
        hwrite = '0;
        hsize = '0;
        hwdata = '0;
    end

    // ==========================================================
    // one transfer; lat counts edges from taking edge to completion, -1 on hang
    task automatic xfer(input int m, input logic wr, input logic [2:0] sz,
                        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                        output logic [DATA_W-1:0] rd, output logic err, output int lat);
        int n;
        lat = -1;
        rd = '0;
        err = 1'b0;
        hsel[m] = 1'b1;
        htrans[m] = 2'b10;
        hwrite[m] = wr;
        hsize[m] = sz;
        haddr[m] = a;
        for (n = 0; n < WAIT_MAX; n++) begin
            @(posedge ref_clk);
            if (hreadyout[m] === 1'b1) break;
        end
        #1;
        hsel[m] = 1'b0;
        htrans[m] = 2'b00;
        haddr[m] = ~a;
        hwdata[m] = wd;
        for (n = 1; n <= WAIT_MAX; n++) begin
            @(posedge ref_clk);
            if (hreadyout[m] === 1'b1) begin
                rd = hrdata[m];
                err = hresp[m];
                lat = n;
                break;
            end
        end
        #1;
        hwdata[m] = ~wd;
    endtask : xfer
endmodule : bsr_ahb_mst

// file: bsr_bank_if.sv
// Purpose: port between the front end and one bank store
// Assumes: one access per cycle, read data one cycle later
// Notes: addr is a word address inside the bank
`timescale 1ns/1ps
interface bsr_bank_if import bsr_pkg::*; ();
    logic en;
    logic we;
    logic [BE_W-1:0] be;
    logic [WORD_AW-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;

    modport ctl (output en, output we, output be, output addr, output wdata, input rdata);
    modport mem (input en, input we, input be, input addr, input wdata, output rdata);
endinterface : bsr_bank_if

// file: bsr_bank_mem.sv
// Purpose: one 128 KB bank store with byte-lane writes
// Assumes: read data registered, valid the cycle after the access
// Notes: a read and a write to one word in one cycle returns the old word
`timescale 1ns/1ps
module bsr_bank_mem import bsr_pkg::*; #(
    parameter int AW = WORD_AW
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // bank port
    bsr_bank_if.mem port
);

    logic [DATA_W-1:0] store [0:(1<<AW)-1];

    // ==========================================================
    // write with byte lanes
    always_ff @(posedge ref_clk) begin
        if (port.en && port.we) begin
            for (int i = 0; i < BE_W; i++) begin
                if (port.be[i]) begin
                    store[port.addr][8*i +: 8] <= port.wdata[8*i +: 8];
                end
            end
        end
    end

    // ==========================================================
    // registered read
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            port.rdata <= RDATA_RST;
        end else begin
            port.rdata <= store[port.addr];
        end
    end

endmodule : bsr_bank_mem

// file: bsr_pkg.sv
// Purpose: shared constants, types and helpers for the banked sram front end
// Assumes: ahb-lite slave ports, single clock ref_clk at 25 MHz
// Notes: lower master index wins bank arbitration
//
// Behaviour
// - the store is 512 KB as four 128 KB banks, each with its own port, served in parallel.
// - each bank is four 32 KB segments, 16 in all, the unit of power state and faults.
// - the three processor-domain banks (384 KB) serve only while that domain is powered.
// - an access to a segment in deep sleep or shut-down raises a segment fault event.
// - the fourth bank sits in the always-on domain and serves whatever the processor-domain power state.
// - eight ahb masters are served: cpu buses, host link bridge, three dmas, fusion engine.
// - a bank clock runs only while a transfer is pending or active on that bank.
package bsr_pkg;

    // ==========================================================
    // geometry
    localparam int NUM_MASTERS = 8;
    localparam int NUM_BANKS = 4;
    localparam int SEGS_PER_BANK = 4;
    localparam int NUM_SEGS = 16;
    localparam int TOTAL_KBYTES = 512;
    localparam int BANK_KBYTES = 128;
    localparam int SEG_KBYTES = 32;
    localparam int ADDR_W = 19;
    localparam int BANK_LSB = 17;
    localparam int SEG_LSB = 15;
    localparam int WORD_AW = 15;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;

    // ==========================================================
    // power domains
    localparam logic [1:0] AON_BANK = 2'h3;
    localparam logic [3:0] PD_BANK_MASK = 4'h7;

    // ==========================================================
    // master slots, priority order
    localparam int MST_SYS = 0;
    localparam int MST_ICODE = 1;
    localparam int MST_DCODE = 2;
    localparam int MST_HOST_LINK_BRIDGE = 3;
    localparam int MST_CFG_DMA = 4;
    localparam int MST_VOICE_DMA = 5;
    localparam int MST_SYS_DMA = 6;
    localparam int MST_FUSION_ENGINE = 7;

    // ==========================================================
    // ahb encodings and reset values
    localparam logic HRESP_OKAY = 1'b0;
    localparam logic HRESP_ERROR = 1'b1;
    localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

    // ==========================================================
    // per-port transfer state
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_WAIT = 5'h02,
        ST_DATA = 5'h04,
        ST_ERR1 = 5'h08,
        ST_ERR2 = 5'h10
    } bsr_state_t;

    // ==========================================================
    // address decode
    function automatic logic [1:0] bank_of(input logic [ADDR_W-1:0] a);
        return a[BANK_LSB+1:BANK_LSB];
    endfunction : bank_of

    function automatic logic [3:0] seg_of(input logic [ADDR_W-1:0] a);
        return a[BANK_LSB+1:SEG_LSB];
    endfunction : seg_of

    function automatic logic [BE_W-1:0] byte_en(input logic [2:0] size, input logic [1:0] a);
        logic [BE_W-1:0] be;
        be = 4'hf;
        case (size)
            3'h0: be = 4'h1 << a;
            3'h1: be = a[1] ? 4'hc : 4'h3;
            default: be = 4'hf;
        endcase
        return be;
    endfunction : byte_en

endpackage : bsr_pkg

// file: bsr_sram_top.sv
// Purpose: banked sram front end with per-master ahb-lite ports and power-aware faults
// Assumes: power state inputs come from logic on ref_clk
// Notes: every transfer takes wait states; contention costs more of them
`timescale 1ns/1ps
module bsr_sram_top import bsr_pkg::*; #(
    parameter int NM = NUM_MASTERS
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // ahb-lite slave ports, one per master
    input wire logic [NM-1:0] hsel,
    input wire logic [NM-1:0][ADDR_W-1:0] haddr,
    input wire logic [NM-1:0][1:0] htrans,
    input wire logic [NM-1:0] hwrite,
    input wire logic [NM-1:0][2:0] hsize,
    input wire logic [NM-1:0][DATA_W-1:0] hwdata,
    input wire logic [NM-1:0] hready_in,
    output logic [NM-1:0][DATA_W-1:0] hrdata,
    output logic [NM-1:0] hreadyout,
    output logic [NM-1:0] hresp,
    // power state
    input wire logic cpu_pd_on,
    input wire logic [NUM_SEGS-1:0] seg_lowpwr,
    // events and clock gating
    output logic [NUM_SEGS-1:0] seg_fault_evt,
    output logic [NUM_BANKS-1:0] mem_clk_en
);

    function automatic logic [NM-1:0] first_one(input logic [NM-1:0] v);
        return v & (~v + {{(NM-1){1'b0}}, 1'b1});
    endfunction : first_one

    // ==========================================================
    // per-port state
    bsr_state_t st_r [NM];
    bsr_state_t st_nxt [NM];
    logic [NM-1:0] hready_r;
    logic [NM-1:0] hresp_r;
    logic [NM-1:0][DATA_W-1:0] hrdata_r;
    logic [NM-1:0] write_r;
    logic [NM-1:0][1:0] bank_r;
    logic [NM-1:0][WORD_AW-1:0] waddr_r;
    logic [NM-1:0][BE_W-1:0] be_r;
    logic [NUM_SEGS-1:0] seg_fault_evt_r;
    logic [NUM_SEGS-1:0] seg_fault_evt_nxt;
    logic [NUM_BANKS-1:0] mem_clk_en_r;
    logic [NUM_BANKS-1:0] mem_clk_en_nxt;

    // ==========================================================
    // address phase decode
    logic [NM-1:0] cap;
    logic [NM-1:0] pd_off;
    logic [NM-1:0] sleep;
    logic [NM-1:0][1:0] cap_bank;
    logic [NM-1:0][3:0] cap_seg;
    logic [NUM_BANKS-1:0][NM-1:0] req;
    logic [NUM_BANKS-1:0][NM-1:0] gnt;
    logic [NM-1:0] served;
    logic [NUM_BANKS-1:0][DATA_W-1:0] bank_rdata;
    logic [NM-1:0][DATA_W-1:0] rd_sel;

    always_comb begin
        for (int m = 0; m < NM; m++) begin
            // a new address phase only lands while this port shows ready
            cap[m] = hsel[m] && htrans[m][1] && hready_in[m] && hready_r[m];
            cap_bank[m] = bank_of(haddr[m]);
            cap_seg[m] = seg_of(haddr[m]);
            pd_off[m] = PD_BANK_MASK[cap_bank[m]] && !cpu_pd_on;
            sleep[m] = seg_lowpwr[cap_seg[m]];
            rd_sel[m] = bank_rdata[bank_r[m]];
        end
    end

    // ==========================================================
    // fixed-priority bank arbitration
    always_comb begin
        served = '0;
        for (int b = 0; b < NUM_BANKS; b++) begin
            for (int m = 0; m < NM; m++) begin
                req[b][m] = (st_r[m] == ST_WAIT) && (bank_r[m] == 2'(b));
            end
            // lowest index wins; several busy lower ports together can starve higher ones
            gnt[b] = first_one(req[b]);
            served = served | gnt[b];
        end
    end

    // ==========================================================
    // port state machines
    always_comb begin
        for (int m = 0; m < NM; m++) begin
            case (st_r[m])
                ST_IDLE, ST_ERR2: begin
                    if (cap[m]) begin
                        st_nxt[m] = (pd_off[m] || sleep[m]) ? ST_ERR1 : ST_WAIT;
                    end else begin
                        st_nxt[m] = ST_IDLE;
                    end
                end
                ST_WAIT: st_nxt[m] = served[m] ? ST_DATA : ST_WAIT;
                ST_DATA: st_nxt[m] = ST_IDLE;
                ST_ERR1: st_nxt[m] = ST_ERR2;
                default: st_nxt[m] = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int m = 0; m < NM; m++) begin
                st_r[m] <= ST_IDLE;
            end
            hready_r <= '1;
            hresp_r <= '0;
        end else begin
            for (int m = 0; m < NM; m++) begin
                st_r[m] <= st_nxt[m];
                hready_r[m] <= (st_nxt[m] == ST_IDLE) || (st_nxt[m] == ST_ERR2);
                hresp_r[m] <= (st_nxt[m] == ST_ERR1) || (st_nxt[m] == ST_ERR2) ? HRESP_ERROR
                                                                              : HRESP_OKAY;
            end
        end
    end

    // ==========================================================
    // captured transfer attributes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            write_r <= '0;
            bank_r <= '0;
            waddr_r <= '0;
            be_r <= '0;
        end else begin
            for (int m = 0; m < NM; m++) begin
                if (cap[m]) begin
                    write_r[m] <= hwrite[m];
                    bank_r[m] <= cap_bank[m];
                    waddr_r[m] <= haddr[m][WORD_AW+1:2];
                    be_r[m] <= byte_en(hsize[m], haddr[m][1:0]);
                end
            end
        end
    end

    // ==========================================================
    // read data return
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_r <= '0;
        end else begin
            for (int m = 0; m < NM; m++) begin
                if (st_r[m] == ST_DATA && !write_r[m]) begin
                    hrdata_r[m] <= rd_sel[m];
                end
            end
        end
    end

    // ==========================================================
    // segment faults and clock gating
    always_comb begin
        seg_fault_evt_nxt = '0;
        mem_clk_en_nxt = '0;
        for (int b = 0; b < NUM_BANKS; b++) begin
            mem_clk_en_nxt[b] = |req[b];
        end
        for (int m = 0; m < NM; m++) begin
            if (cap[m] && sleep[m]) begin
                seg_fault_evt_nxt[cap_seg[m]] = 1'b1;
            end
            if (cap[m] && !pd_off[m] && !sleep[m]) begin
                mem_clk_en_nxt[cap_bank[m]] = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            seg_fault_evt_r <= '0;
            mem_clk_en_r <= '0;
        end else begin
            seg_fault_evt_r <= seg_fault_evt_nxt;
            mem_clk_en_r <= mem_clk_en_nxt;
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hready_r;
    assign hresp = hresp_r;
    assign seg_fault_evt = seg_fault_evt_r;
    assign mem_clk_en = mem_clk_en_r;

    // ==========================================================
    // bank ports and stores
    bsr_bank_if bus [NUM_BANKS] ();

    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        always_comb begin
            bus[b].en = |gnt[b];
            bus[b].we = 1'b0;
            bus[b].be = '0;
            bus[b].addr = '0;
            bus[b].wdata = '0;
            for (int m = 0; m < NM; m++) begin
                if (gnt[b][m]) begin
                    bus[b].we = write_r[m];
                    bus[b].be = be_r[m];
                    bus[b].addr = waddr_r[m];
                    bus[b].wdata = hwdata[m];
                end
            end
        end
        assign bank_rdata[b] = bus[b].rdata;

        bsr_bank_mem u_mem (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .port(bus[b])
        );
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    for (genvar m = 0; m < NM; m++) begin : g_chk_m
        sequence s_err_resp;
            (st_r[m] == ST_ERR1 && !hready_r[m] && hresp_r[m])
            ##1 (st_r[m] == ST_ERR2 && hready_r[m] && hresp_r[m]);
        endsequence

        chk_pd_error: assert property (cap[m] && pd_off[m] |=> s_err_resp)
            else $error("processor-domain access while unpowered not errored");
        chk_aon_served: assert property (
            cap[m] && cap_bank[m] == AON_BANK && !sleep[m] |=> st_r[m] == ST_WAIT)
            else $error("always-on bank access not queued");
        chk_seg_event: assert property (
            cap[m] && sleep[m] |=> seg_fault_evt_r[$past(cap_seg[m])] and s_err_resp)
            else $error("sleeping segment access gave no fault event");
        chk_wait_stall: assert property (
            st_r[m] == ST_WAIT |-> !hready_r[m] && hresp_r[m] == HRESP_OKAY)
            else $error("waiting port not stalled");
        chk_done_okay: assert property (
            st_r[m] == ST_DATA |=> hready_r[m] && !hresp_r[m] && st_r[m] != ST_DATA)
            else $error("served transfer did not complete okay");
        chk_read_data: assert property (
            st_r[m] == ST_DATA && !write_r[m] |=> hrdata_r[m] == $past(rd_sel[m]))
            else $error("read data not returned from bank");
    end

    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_chk_b
        chk_grant_onehot: assert property ($onehot0(gnt[b]))
            else $error("bank granted to more than one master");
        chk_bank_parallel: assert property (
            req[b] != '0 |-> gnt[b] != '0 && (!req[b][0] || gnt[b][0]))
            else $error("pending bank request left ungranted");
        chk_clk_gate: assert property (req[b] != '0 |-> mem_clk_en_r[b])
            else $error("bank clock gated while transfer pending");
    end

endmodule : bsr_sram_top

// file: bsr_sram_top_bench.sv
// Purpose: self-checking bench for the banked sram front end
// Assumes: all ports driven by the master model, hready looped back
// Notes: latencies are the uncontended figures of the port contract, except the queued ones in t_contend
`timescale 1ns/1ps
module bsr_sram_top_bench import bsr_pkg::*;;
    logic ref_clk;
    logic rst_n;
    logic [NUM_MASTERS-1:0] hsel, hwrite, hready_in, hreadyout, hresp;
    logic [NUM_MASTERS-1:0][ADDR_W-1:0] haddr;
    logic [NUM_MASTERS-1:0][1:0] htrans;
    logic [NUM_MASTERS-1:0][2:0] hsize;
    logic [NUM_MASTERS-1:0][DATA_W-1:0] hwdata, hrdata;
    logic cpu_pd_on;
    logic [NUM_SEGS-1:0] seg_lowpwr, seg_fault_evt, evt_acc;
    logic [NUM_BANKS-1:0] mem_clk_en, clk_acc;
    int evt_cnt;
    int fails;
    int total_checks;

    assign hready_in = hreadyout;

    bsr_sram_top #(.NM(NUM_MASTERS)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready_in(hready_in), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cpu_pd_on(cpu_pd_on), .seg_lowpwr(seg_lowpwr), .seg_fault_evt(seg_fault_evt),
        .mem_clk_en(mem_clk_en));

    bsr_ahb_mst #(.NM(NUM_MASTERS)) i_mst (.ref_clk(ref_clk), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));

    // ==========================================================
    // clock and event monitors
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        evt_acc <= evt_acc | seg_fault_evt;
        clk_acc <= clk_acc | mem_clk_en;
        evt_cnt <= evt_cnt + $countones(seg_fault_evt);
    end

    // ==========================================================
    // helpers
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic clear_mon();
        evt_acc = '0;
        clk_acc = '0;
        evt_cnt = 0;
    endtask : clear_mon

    function automatic logic [ADDR_W-1:0] sa(input int s);
        return (ADDR_W'(s) << SEG_LSB) | 19'h7ffc;
    endfunction : sa

    function automatic logic [DATA_W-1:0] pt(input int s);
        return 32'h5a00_0000 | DATA_W'(s);
    endfunction : pt

    // read data is compared only for reads expected to complete okay
    task automatic do1(input int m, input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic e, input int l);
        logic [DATA_W-1:0] rd;
        logic err;
        int lat;
        i_mst.xfer(m, wr, 3'h2, a, d, rd, err, lat);
        if (lat < 0) begin
            fails++;
            tally_and_finish();
        end else begin
            check(err, e);
            check(lat, l);
            if (!wr && !e) check(rd, d);
        end
    endtask : do1

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // ==========================================================
    // scenarios
    task automatic t_reset();
        check(hreadyout, 8'hff);
        check(hresp, 8'h00);
        check(hrdata[0], 32'h0000_0000);
        check(mem_clk_en, 4'h0);
        check(seg_fault_evt, 16'h0000);
    endtask : t_reset

    // every segment written by one master, read back by another
    task automatic t_segments();
        for (int s = 0; s < NUM_SEGS; s++) begin
            do1(s % 8, 1'b1, sa(s), pt(s), 1'b0, 3);
            clear_mon();
            do1((s + 3) % 8, 1'b0, sa(s), pt(s), 1'b0, 3);
            cyc(1);
            check(clk_acc, 4'h1 << (s / 4));
            check(mem_clk_en, 4'h0);
        end
    endtask : t_segments

    task automatic t_parallel();
        fork
            do1(4, 1'b0, sa(0), pt(0), 1'b0, 3);
            do1(5, 1'b0, sa(4), pt(4), 1'b0, 3);
            do1(6, 1'b0, sa(8), pt(8), 1'b0, 3);
            do1(7, 1'b0, sa(12), pt(12), 1'b0, 3);
        join
    endtask : t_parallel

    // narrow writes land only in their byte lanes
    task automatic t_lanes();
        logic [DATA_W-1:0] rd;
        logic err;
        int lat;
        do1(0, 1'b1, 19'h0_fff8, 32'h5a5a_5a5a, 1'b0, 3);
        i_mst.xfer(2, 1'b1, 3'h0, 19'h0_fff9, 32'h0000_ab00, rd, err, lat);
        check(lat, 3);
        check(err, 1'b0);
        i_mst.xfer(3, 1'b1, 3'h1, 19'h0_fffa, 32'h1234_0000, rd, err, lat);
        check(lat, 3);
        check(err, 1'b0);
        do1(4, 1'b0, 19'h0_fff8, 32'h1234_ab5a, 1'b0, 3);
    endtask : t_lanes

    // three masters on one bank: one grant per cycle, lowest index first
    task automatic t_contend();
        fork
            do1(7, 1'b0, sa(9), pt(9), 1'b0, 5);
            do1(0, 1'b0, sa(8), pt(8), 1'b0, 3);
            do1(3, 1'b0, sa(10), pt(10), 1'b0, 4);
        join
    endtask : t_contend

    task automatic t_pd_off();
        cpu_pd_on = 1'b0;
        clear_mon();
        for (int b = 0; b < 3; b++) begin
            do1(b, 1'b1, sa(b * 4), 32'hdead_0000, 1'b1, 2);
            do1(b + 4, 1'b0, sa(b * 4 + 1), 32'h0, 1'b1, 2);
        end
        check(evt_acc, 16'h0000);
        check(clk_acc, 4'h0);
        do1(6, 1'b1, 19'h6_0000, 32'hc0de_0003, 1'b0, 3);
        do1(1, 1'b0, 19'h6_0000, 32'hc0de_0003, 1'b0, 3);
        cpu_pd_on = 1'b1;
        do1(2, 1'b0, sa(4), pt(4), 1'b0, 3);
    endtask : t_pd_off

    // sleeping segment faults, its neighbour still serves
    task automatic t_sleep();
        for (int s = 0; s < NUM_SEGS; s++) begin
            seg_lowpwr = 16'h0001 << s;
            clear_mon();
            do1(s % 8, 1'b1, sa(s), 32'hdead_beef, 1'b1, 2);
            cyc(1);
            check(evt_acc, 16'h0001 << s);
            check(evt_cnt, 1);
            check(clk_acc, 4'h0);
            do1((s + 1) % 8, 1'b0, sa(s ^ 1), pt(s ^ 1), 1'b0, 3);
            seg_lowpwr = '0;
            do1((s + 2) % 8, 1'b0, sa(s), pt(s), 1'b0, 3);
        end
    endtask : t_sleep

    // ==========================================================
    // main sequence
    initial begin
        fails = 0;
        total_checks = 0;
        rst_n = 1'b0;
        cpu_pd_on = 1'b1;
        seg_lowpwr = '0;
        clear_mon();
        repeat (4) @(posedge ref_clk);
        #1;
        t_reset();
        rst_n = 1'b1;
        cyc(1);
        t_segments();
        t_parallel();
        t_lanes();
        t_contend();
        t_pd_off();
        t_sleep();
        tally_and_finish();
    end
endmodule : bsr_sram_top_bench
